// ### design/opreg_bank.sv
// operational register bank at data addresses 00h..08h of an 8-bit core
// assumes the instruction logic drives one request per cycle on ref_clk
// and that the general data memory sits outside, reached through the window port
`timescale 1ns/1ps
`include "opreg_regs.svh"
module opreg_bank (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // register access
   input wire opreg_pkg::reg_req_t req,
   output logic [7:0] rdata,
   // indirect window to data memory
   output logic win_rd,
   output logic win_wr,
   output logic [1:0] win_bank,
   output logic [5:0] win_addr,
   output logic [7:0] win_wdata,
   input wire logic [7:0] win_rdata,
   // counter source
   input wire logic tcc_pin,
   input wire logic tcc_src_ext,
   input wire logic tcc_edge_fall,
   input wire logic instr_cycle,
   // program counter control
   input wire opreg_pkg::pc_op_t pc_op,
   input wire logic [9:0] pc_operand,
   input wire logic [7:0] acc,
   output logic [11:0] pc,
   output logic [1:0] stack_depth_used,
   // flags
   input wire opreg_pkg::flag_evt_t flag_evt,
   output logic [7:0] status,
   // ports
   input wire logic [7:0] port_a_direction,
   input wire logic [7:0] port_b_direction,
   input wire logic [7:0] port_c_direction,
   input wire logic [7:0] port_d_direction,
   input wire logic [7:0] port_a_pin_in,
   input wire logic [7:0] port_b_pin_in,
   input wire logic [7:0] port_c_pin_in,
   input wire logic [7:0] port_d_pin_in,
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe,
   output logic [7:0] port_c_out,
   output logic [7:0] port_c_oe,
   output logic [7:0] port_d_out,
   output logic [7:0] port_d_oe,
   output logic control_page_select
);
   // ---------------------------------------------------------------
   // storage
   // ---------------------------------------------------------------
   logic [7:0] tcc_q;
   logic [7:0] status_q;
   logic [7:0] rsp_q;
   logic [7:0] port_a_q;
   logic [7:0] port_b_q;
   logic [7:0] port_c_q;
   logic [7:0] port_d_q;
   logic [11:0] pc_q;
   logic [11:0] pc_d;
   logic [11:0] stack_q [0:`STACK_DEPTH-1];
   logic [2:0] sp_q;
   logic [2:0] tcc_sync_q;
   logic [7:0] pin_a_sync, pin_b_sync, pin_c_sync, pin_d_sync;

   logic wr_tcc, wr_pcl, wr_st, wr_rsp, wr_pa, wr_pb, wr_pc, wr_pd;
   logic tcc_tick;
   logic [1:0] page_sel;

   assign wr_tcc = req.wr && req.addr == `OFS_TCC;
   assign wr_pcl = req.wr && req.addr == `OFS_PC_LOW;
   assign wr_st = req.wr && req.addr == `OFS_STATUS;
   assign wr_rsp = req.wr && req.addr == `OFS_RSP;
   assign wr_pa = req.wr && req.addr == `OFS_PORT_A;
   assign wr_pb = req.wr && req.addr == `OFS_PORT_B;
   assign wr_pc = req.wr && req.addr == `OFS_PORT_C;
   assign wr_pd = req.wr && req.addr == `OFS_PORT_D;
   assign page_sel = {status_q[`ST_PAGE_HI], status_q[`ST_PAGE_LO]};

   // ---------------------------------------------------------------
   // indirect window
   // ---------------------------------------------------------------
   // address zero has no storage; it forwards through the pointer
   assign win_rd = req.rd && req.addr == `OFS_INDIRECT;
   assign win_wr = req.wr && req.addr == `OFS_INDIRECT;
   assign win_bank = rsp_q[7:6];
   assign win_addr = rsp_q[5:0];
   assign win_wdata = req.wdata;

   // ---------------------------------------------------------------
   // time clock counter
   // ---------------------------------------------------------------
   // pin is asynchronous; two stages, third only for the edge compare
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tcc_sync_q <= 3'h0;
      end else begin
         tcc_sync_q <= {tcc_sync_q[1:0], tcc_pin};
      end
   end

   always_comb begin
      if (tcc_src_ext) begin
         if (tcc_edge_fall) begin
            tcc_tick = tcc_sync_q[2] && !tcc_sync_q[1];
         end else begin
            tcc_tick = !tcc_sync_q[2] && tcc_sync_q[1];
         end
      end else begin
         tcc_tick = instr_cycle;
      end
   end

   // a program write takes precedence over a tick in the same cycle
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tcc_q <= `BYTE_RST;
      end else if (wr_tcc) begin
         tcc_q <= req.wdata;
      end else if (tcc_tick) begin
         tcc_q <= tcc_q + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // program counter and return stack
   // ---------------------------------------------------------------
   always_comb begin
      pc_d = pc_q;
      if (wr_pcl) begin
         // bits 8,9 kept, page bits refreshed
         pc_d = {page_sel, pc_q[9:8], req.wdata};
      end else begin
         case (pc_op)
            opreg_pkg::PC_STEP: pc_d = pc_q + 12'h001;
            opreg_pkg::PC_JUMP: pc_d = {page_sel, pc_operand};
            opreg_pkg::PC_CALL: pc_d = {page_sel, pc_operand};
            opreg_pkg::PC_RETURN: pc_d = stack_q[sp_q - 3'h1];
            opreg_pkg::PC_MOVE_ACC: pc_d = {page_sel, pc_q[9:8], acc};
            opreg_pkg::PC_ADD_ACC: pc_d = pc_q + {4'h0, acc};
            opreg_pkg::PC_HOLD: pc_d = pc_q;
            default: pc_d = pc_q;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pc_q <= `PC_RST;
      end else begin
         pc_q <= pc_d;
      end
   end

   // circular stack: overflow overwrites the oldest entry
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sp_q <= 3'h0;
         for (int i = 0; i < `STACK_DEPTH; i++) begin
            stack_q[i] <= `PC_RST;
         end
      end else if (!wr_pcl && pc_op == opreg_pkg::PC_CALL) begin
         stack_q[sp_q] <= pc_q + 12'h001;
         sp_q <= sp_q + 3'h1;
      end else if (!wr_pcl && pc_op == opreg_pkg::PC_RETURN) begin
         sp_q <= sp_q - 3'h1;
      end
   end

   assign pc = pc_q;
   assign stack_depth_used = sp_q[1:0];

   // ---------------------------------------------------------------
   // status flags
   // ---------------------------------------------------------------
   // reset covers power up and reset pin: both give timeout=1, power-down=1
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         status_q <= `STATUS_RST;
      end else begin
         if (wr_st) begin
            status_q[`ST_PAGE_HI] <= req.wdata[`ST_PAGE_HI];
            status_q[`ST_PAGE_LO] <= req.wdata[`ST_PAGE_LO];
            status_q[`ST_ZERO] <= req.wdata[`ST_ZERO];
            status_q[`ST_AUX] <= req.wdata[`ST_AUX];
            status_q[`ST_CARRY] <= req.wdata[`ST_CARRY];
         end
         if (flag_evt.arith_valid) begin
            status_q[`ST_ZERO] <= flag_evt.zero;
            status_q[`ST_AUX] <= flag_evt.aux_carry;
            status_q[`ST_CARRY] <= flag_evt.carry;
         end
         // watchdog event forms the 0,x pair; wake from pin forms 1,x
         if (flag_evt.wdt_timeout) begin
            status_q[`ST_TIMEOUT] <= 1'b0;
         end else if (flag_evt.sleep_instr || flag_evt.wdt_clear_instr || flag_evt.reset_pin_wake) begin
            status_q[`ST_TIMEOUT] <= 1'b1;
         end
         if (flag_evt.wdt_clear_instr) begin
            status_q[`ST_PWRDN] <= 1'b1;
         end else if (flag_evt.sleep_instr) begin
            status_q[`ST_PWRDN] <= 1'b0;
         end
         status_q[7] <= 1'b0;
      end
   end

   assign status = status_q;

   // ---------------------------------------------------------------
   // pointer and ports
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rsp_q <= `BYTE_RST;
      end else if (wr_rsp) begin
         rsp_q <= req.wdata;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         port_a_q <= `BYTE_RST;
         port_b_q <= `BYTE_RST;
         port_c_q <= `BYTE_RST;
         port_d_q <= `BYTE_RST;
      end else begin
         if (wr_pa) begin
            port_a_q <= req.wdata & `PORT_A_WMASK;
         end
         if (wr_pb) begin
            port_b_q <= req.wdata;
         end
         if (wr_pc) begin
            port_c_q <= req.wdata;
         end
         if (wr_pd) begin
            port_d_q <= req.wdata;
         end
      end
   end

   // pins come from outside the clock domain
   opreg_pin_sync #(
      .W(8)
   ) port_a_sync_i (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pin_in(port_a_pin_in),
      .pin_sync(pin_a_sync)
   );

   opreg_pin_sync #(
      .W(8)
   ) port_b_sync_i (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pin_in(port_b_pin_in),
      .pin_sync(pin_b_sync)
   );

   opreg_pin_sync #(
      .W(8)
   ) port_c_sync_i (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pin_in(port_c_pin_in),
      .pin_sync(pin_c_sync)
   );

   opreg_pin_sync #(
      .W(8)
   ) port_d_sync_i (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .pin_in(port_d_pin_in),
      .pin_sync(pin_d_sync)
   );

   // direction bit 1 means input; only the data nibble of port A drives
   assign port_a_oe = {~port_a_direction[7:4], 4'h0};
   assign port_b_oe = ~port_b_direction;
   assign port_c_oe = ~port_c_direction;
   assign port_d_oe = ~port_d_direction;
   assign port_a_out = {port_a_q[7:4], 4'h0};
   assign port_b_out = port_b_q;
   assign port_c_out = port_c_q;
   assign port_d_out = port_d_q;
   assign control_page_select = port_a_q[0];

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   // input bits read the pin, output bits read the latch; port A bits 3..1 read zero and bit 0 always reads the latch
   always_comb begin
      case (req.addr)
         `OFS_INDIRECT: rdata = win_rdata;
         `OFS_TCC: rdata = tcc_q;
         `OFS_PC_LOW: rdata = pc_q[7:0];
         `OFS_STATUS: rdata = status_q & `STATUS_WMASK | (status_q & 8'h18);
         `OFS_RSP: rdata = rsp_q;
         `OFS_PORT_A: rdata = {(port_a_direction[7:4] & pin_a_sync[7:4]) | (~port_a_direction[7:4] & port_a_q[7:4]),
                               3'h0, port_a_q[0]};
         `OFS_PORT_B: rdata = (port_b_direction & pin_b_sync) | (~port_b_direction & port_b_q);
         `OFS_PORT_C: rdata = (port_c_direction & pin_c_sync) | (~port_c_direction & port_c_q);
         `OFS_PORT_D: rdata = (port_d_direction & pin_d_sync) | (~port_d_direction & port_d_q);
         default: rdata = 8'h00;
      endcase
   end
endmodule : opreg_bank

// ---------------------------------------------------------------
// two-stage synchroniser for pins outside the clock domain
// ---------------------------------------------------------------
module opreg_pin_sync #(
   parameter int W = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // pins in, settled copy out
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] pin_sync
);
   logic [W-1:0] stage1_q;
   logic [W-1:0] stage2_q;

   // only the second stage leaves; the first may still be settling
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage1_q <= {W{1'b0}};
         stage2_q <= {W{1'b0}};
      end else begin
         stage1_q <= pin_in;
         stage2_q <= stage1_q;
      end
   end

   assign pin_sync = stage2_q;
endmodule : opreg_pin_sync

// ### design/opreg_pkg.sv
// types shared by the operational register bank and its core
// assumes opreg_regs.svh on the include path
`include "opreg_regs.svh"
package opreg_pkg;
   typedef enum logic [2:0] {
      PC_STEP,
      PC_JUMP,
      PC_CALL,
      PC_RETURN,
      PC_MOVE_ACC,
      PC_ADD_ACC,
      PC_HOLD
   } pc_op_t;
   // register access from the instruction logic
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   // flag update events from instruction logic and watchdog
   typedef struct packed {
      logic sleep_instr;
      logic wdt_clear_instr;
      logic wdt_timeout;
      logic reset_pin_wake;
      logic arith_valid;
      logic zero;
      logic aux_carry;
      logic carry;
   } flag_evt_t;
endpackage : opreg_pkg

// ### design/opreg_regs.svh
// offsets, field positions, reset values and counts of the operational register bank
// assumes inclusion by bare name from the package and the bank module
`ifndef OPREG_REGS_SVH
`define OPREG_REGS_SVH
// register offsets
`define OFS_INDIRECT 8'h00
`define OFS_TCC 8'h01
`define OFS_PC_LOW 8'h02
`define OFS_STATUS 8'h03
`define OFS_RSP 8'h04
`define OFS_PORT_A 8'h05
`define OFS_PORT_B 8'h06
`define OFS_PORT_C 8'h07
`define OFS_PORT_D 8'h08
// status fields
`define ST_PAGE_HI 6
`define ST_PAGE_LO 5
`define ST_TIMEOUT 4
`define ST_PWRDN 3
`define ST_ZERO 2
`define ST_AUX 1
`define ST_CARRY 0
// write masks of implemented bits
`define STATUS_WMASK 8'h67
`define PORT_A_WMASK 8'hF1
// reset values
`define STATUS_RST 8'h18
`define BYTE_RST 8'h00
`define PC_RST 12'h000
// sizes
`define PC_W 12
`define PAGE_BASE_STEP 12'h400
`define STACK_DEPTH 8
`define STACK_IDX_W 3
`endif

// ### test/opreg_bank_monitor.sv
// checker of the operational register bank, sees its ports only
// assumes bind into every opreg_bank instance
`timescale 1ns/1ps
`include "opreg_regs.svh"
module opreg_bank_monitor (
   // clock and reset
   input wire logic ref_clk,
   input wire logic sys_rst,
   // access and window
   input wire opreg_pkg::reg_req_t req,
   input wire logic [7:0] rdata,
   input wire logic win_rd,
   input wire logic [7:0] win_rdata,
   input wire logic [1:0] win_bank,
   input wire logic [5:0] win_addr,
   // program counter and flags
   input wire opreg_pkg::pc_op_t pc_op,
   input wire logic [9:0] pc_operand,
   input wire logic [7:0] acc,
   input wire logic [11:0] pc,
   input wire opreg_pkg::flag_evt_t flag_evt,
   input wire logic [7:0] status,
   // ports
   input wire logic [7:0] port_b_direction,
   input wire logic [7:0] port_b_oe
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // a write to the low pc byte overrides the pc operation
   logic pc_wr;
   assign pc_wr = req.wr && req.addr == `OFS_PC_LOW;
   sequence call_then_ret_s;
      pc_op == opreg_pkg::PC_CALL && !pc_wr ##1 pc_op == opreg_pkg::PC_RETURN && !pc_wr;
   endsequence
   chk_window_read: assert property (req.rd && req.addr == `OFS_INDIRECT |-> win_rd && rdata == win_rdata)
      else $error("indirect read not routed to window");
   chk_pointer_window: assert property (req.wr && req.addr == `OFS_RSP |=> {win_bank, win_addr} == $past(req.wdata))
      else $error("pointer write not seen on window");
   chk_jump_load: assert property (pc_op == opreg_pkg::PC_JUMP && !pc_wr
      |=> pc == {$past(status[6:5]), $past(pc_operand)})
      else $error("jump target wrong");
   chk_call_return: assert property (call_then_ret_s |=> pc == $past(pc, 2) + 12'h001)
      else $error("return address wrong");
   chk_move_acc: assert property (pc_op == opreg_pkg::PC_MOVE_ACC && !pc_wr
      |=> pc == {$past(status[6:5]), $past(pc[9:8]), $past(acc)})
      else $error("accumulator move wrong");
   chk_add_acc: assert property (pc_op == opreg_pkg::PC_ADD_ACC && !pc_wr |=> pc == $past(pc) + {4'h0, $past(acc)})
      else $error("relative branch wrong");
   chk_step_count: assert property (pc_op == opreg_pkg::PC_STEP && !pc_wr |=> pc == $past(pc) + 12'h001)
      else $error("pc step wrong");
   chk_sleep_flags: assert property (flag_evt.sleep_instr && !flag_evt.wdt_clear_instr && !flag_evt.wdt_timeout
      |=> status[4:3] == 2'b10)
      else $error("sleep flags wrong");
   chk_wdt_timeout: assert property (flag_evt.wdt_timeout |=> !status[4])
      else $error("timeout flag not cleared");
   chk_arith_flags: assert property (flag_evt.arith_valid
      |=> status[2:0] == $past({flag_evt.zero, flag_evt.aux_carry, flag_evt.carry}))
      else $error("arithmetic flags wrong");
   chk_unused_zero: assert property (status[7] == 1'b0)
      else $error("unused status bit set");
   chk_port_dir: assert property (port_b_oe == ~port_b_direction)
      else $error("port enable does not follow direction");
endmodule : opreg_bank_monitor
bind opreg_bank opreg_bank_monitor opreg_bank_monitor_i (.ref_clk, .sys_rst, .req, .rdata, .win_rd, .win_rdata,
   .win_bank, .win_addr, .pc_op, .pc_operand, .acc, .pc, .flag_evt, .status, .port_b_direction, .port_b_oe);

// ### test/opreg_data_mem.sv
// data memory model behind the indirect window
// assumes window strobes come from the bank in the cycle of the access
`timescale 1ns/1ps
module opreg_data_mem (
   // clock
   input wire logic ref_clk,
   // window
   input wire logic win_rd,
   input wire logic win_wr,
   input wire logic [1:0] win_bank,
   input wire logic [5:0] win_addr,
   input wire logic [7:0] win_wdata,
   output logic [7:0] win_rdata
);
   logic [7:0] mem [256];
   logic [7:0] last_q = 8'h00;
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
   // bank bits on top of the six pointer bits
   always @(posedge ref_clk) begin
      if (win_wr) mem[{win_bank, win_addr}] <= win_wdata;
      if (win_rd) last_q <= win_rdata;
   end
   // released bus shows the inverse so stale data cannot pass
   assign win_rdata = win_rd ? mem[{win_bank, win_addr}] : ~last_q;
endmodule : opreg_data_mem

// ### test/test_opreg_bank.sv
// self-checking bench of the operational register bank
// assumes package, bank, monitor and data memory model compiled first
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin failures++; \
   $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module test_opreg_bank;
   logic ref_clk = 1'b0, sys_rst = 1'b1, tcc_pin = 1'b0, tcc_src_ext = 1'b0, tcc_edge_fall = 1'b0;
   logic instr_cycle = 1'b0, win_rd, win_wr, control_page_select;
   logic [1:0] win_bank, stack_depth_used;
   logic [5:0] win_addr;
   logic [7:0] rdata, win_wdata, win_rdata, status, port_a_oe, port_b_oe, port_b_out;
   logic [7:0] port_a_out, port_c_out, port_d_out, port_c_oe, port_d_oe;
   logic [7:0] acc = 8'h00, dir = 8'h00, pin = 8'hA5;
   logic [9:0] pc_operand = 10'h000;
   logic [11:0] pc;
   opreg_pkg::reg_req_t req = '0;
   opreg_pkg::pc_op_t pc_op = opreg_pkg::PC_HOLD;
   opreg_pkg::flag_evt_t flag_evt = '0;
   int checked = 0, failures = 0, cycles = 0;
   logic [7:0] rst_exp [10] = '{8'hA5, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] ones_exp [9] = '{8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hF1, 8'hFF, 8'hFF, 8'hFF, 8'h00};
   logic [7:0] ev_code [6] = '{8'h80, 8'h20, 8'h10, 8'h40, 8'h20, 8'h0D};
   logic [4:0] ev_exp [6] = '{5'h10, 5'h00, 5'h10, 5'h18, 5'h08, 5'h0D};
   opreg_bank opreg_bank_i (.ref_clk, .sys_rst, .req, .rdata, .win_rd, .win_wr, .win_bank, .win_addr,
      .win_wdata, .win_rdata, .tcc_pin, .tcc_src_ext, .tcc_edge_fall, .instr_cycle, .pc_op, .pc_operand,
      .acc, .pc, .stack_depth_used, .flag_evt, .status, .port_a_direction(dir), .port_b_direction(dir),
      .port_c_direction(dir), .port_d_direction(dir), .port_a_pin_in(pin), .port_b_pin_in(pin),
      .port_c_pin_in(pin), .port_d_pin_in(pin), .port_a_out, .port_a_oe, .port_b_out, .port_b_oe,
      .port_c_out, .port_c_oe, .port_d_out, .port_d_oe, .control_page_select);
   opreg_data_mem opreg_data_mem_i (.ref_clk, .win_rd, .win_wr, .win_bank, .win_addr, .win_wdata, .win_rdata);
   always #50 ref_clk = ~ref_clk;
   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic put(input logic rd, input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      req <= '{rd: rd, wr: wr, addr: a, wdata: d};
   endtask : put
   // idle after each write so a held strobe never repeats it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      put(1'b0, 1'b1, a, d);
      put(1'b0, 1'b0, a, d);
   endtask : wr
   task automatic get(input logic [7:0] a, input logic [7:0] ex);
      put(1'b1, 1'b0, a, 8'h00);
      @(negedge ref_clk);
      `CHK("rdata", ex, rdata)
   endtask : get
   task automatic pcop(input opreg_pkg::pc_op_t o, input logic [9:0] v, input logic [7:0] a, input logic [11:0] ex);
      @(posedge ref_clk);
      pc_op <= o;
      pc_operand <= v;
      acc <= a;
      @(posedge ref_clk);
      pc_op <= opreg_pkg::PC_HOLD;
      @(negedge ref_clk);
      `CHK("pc", ex, pc)
   endtask : pcop
   task automatic evt(input logic [7:0] e, input logic [4:0] ex);
      @(posedge ref_clk);
      flag_evt <= opreg_pkg::flag_evt_t'(e);
      @(posedge ref_clk);
      flag_evt <= '0;
      @(negedge ref_clk);
      `CHK("status", ex, status[4:0])
   endtask : evt
   task automatic complete_run;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : complete_run
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         failures++;
         complete_run;
      end
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      sys_rst <= 1'b0;
      foreach (rst_exp[i]) get(8'(i), rst_exp[i]);
      foreach (ones_exp[i]) begin
         wr(8'(i + 1), 8'hFF);
         get(8'(i + 1), ones_exp[i]);
      end
      `CHK("page", 1'b1, control_page_select)
      `CHK("port", 8'hFF, port_b_out)
      `CHK("ports", {8'hF0, 8'hFF, 8'hFF}, {port_a_out, port_c_out, port_d_out})
      @(posedge ref_clk) dir <= 8'h0F;
      repeat (4) @(posedge ref_clk);
      get(8'h06, 8'hF5);
      get(8'h05, 8'hF1);
      `CHK("oe", 8'hF0, port_a_oe)
      `CHK("oes", {8'hF0, 8'hF0, 8'hF0}, {port_b_oe, port_c_oe, port_d_oe})
      @(posedge ref_clk) dir <= 8'hF0;
      repeat (4) @(posedge ref_clk);
      get(8'h05, 8'hA1);
      @(posedge ref_clk) dir <= 8'h00;
      wr(8'h04, 8'hC5);
      @(negedge ref_clk);
      `CHK("window", 8'hC5, {win_bank, win_addr})
      get(8'h00, 8'h60);
      wr(8'h00, 8'h3C);
      get(8'h00, 8'h3C);
      wr(8'h01, 8'h10);
      repeat (5) begin
         @(posedge ref_clk) instr_cycle <= 1'b1;
         @(posedge ref_clk) instr_cycle <= 1'b0;
      end
      get(8'h01, 8'h15);
      @(posedge ref_clk) tcc_src_ext <= 1'b1;
      for (int f = 0; f < 2; f++) begin
         @(posedge ref_clk) tcc_edge_fall <= f[0];
         repeat (3) begin
            repeat (3) @(posedge ref_clk);
            tcc_pin <= 1'b1;
            repeat (3) @(posedge ref_clk);
            tcc_pin <= 1'b0;
         end
         repeat (5) @(posedge ref_clk);
         get(8'h01, 8'(8'h18 + 3 * f));
      end
      @(posedge ref_clk) tcc_src_ext <= 1'b0;
      wr(8'h03, 8'h40);
      pcop(opreg_pkg::PC_JUMP, 10'h3FF, 8'h00, 12'hBFF);
      pcop(opreg_pkg::PC_CALL, 10'h123, 8'h00, 12'h923);
      `CHK("depth", 2'h1, stack_depth_used)
      wr(8'h03, 8'h20);
      pcop(opreg_pkg::PC_RETURN, 10'h000, 8'h00, 12'hC00);
      pcop(opreg_pkg::PC_MOVE_ACC, 10'h000, 8'h5A, 12'h45A);
      pcop(opreg_pkg::PC_ADD_ACC, 10'h000, 8'hF0, 12'h54A);
      pcop(opreg_pkg::PC_STEP, 10'h000, 8'h00, 12'h54B);
      // call straight into return: the pushed address must come back
      @(posedge ref_clk) pc_op <= opreg_pkg::PC_CALL;
      @(posedge ref_clk) pc_op <= opreg_pkg::PC_RETURN;
      @(posedge ref_clk) pc_op <= opreg_pkg::PC_HOLD;
      @(negedge ref_clk);
      `CHK("pc", 12'h54C, pc)
      `CHK("depth", 2'h0, stack_depth_used)
      wr(8'h02, 8'h77);
      @(negedge ref_clk);
      `CHK("pc", 12'h577, pc)
      foreach (ev_code[i]) evt(ev_code[i], ev_exp[i]);
      @(posedge ref_clk) sys_rst <= 1'b1;
      @(posedge ref_clk) sys_rst <= 1'b0;
      get(8'h03, 8'h18);
      `CHK("pc", 12'h000, pc)
      complete_run;
   end
endmodule : test_opreg_bank
